// File: shared/gpio_mux_regs.svh
// Register offsets, field positions, reset values and function codes of the pin-function mux.
// Operation
// RL1: Each pin has a 2-bit function select.
// RL2: Ten-pin port code 01 PHY, 10 keypad.
// RL3: Single pin: 00 I/O, 01 wait, 10 interrupt.
// RL4: Single-pin config resets with wait selected.
// RL5: Thirteen-pin port routes three peripheral function sets.
// RL6: Last two pins interrupts; final pin overcurrent.
// RL7: Thirteen-pin config resets to all I/O.
// RL8: One pull-up enable bit per pin.
// RL9: Pull-ups reset disabled.
// RL10: One output-mode enable bit per pin.
// RL11: Output-mode bit applies only in I/O mode.
// RL12: I/O output pins drive stored data bit.
// RL13: Reserved output-data bits ignore writes.
// RL14: Input register shows pin level always.
// RL15: Reserved input-data bits read zero.
// RL16: Direction and output registers reset zero.
// RL17: Ten-pin config register resets to zero.
// RL18: First ten-pin pin: receive error, column 0.
// RL19: Pin inputs pass two-stage synchroniser.
// RL20: Disabled I/O pins float; pull-up per bit.
`ifndef GPIO_MUX_REGS_SVH
`define GPIO_MUX_REGS_SVH

`define ADDR_P2_FUNC    32'hfff83020
`define ADDR_P2_DIR     32'hfff83024
`define ADDR_P2_OUT     32'hfff83028
`define ADDR_P2_IN      32'hfff8302c
`define ADDR_P4_FUNC    32'hfff83040
`define ADDR_P4_DIR     32'hfff83044
`define ADDR_P4_OUT     32'hfff83048
`define ADDR_P4_IN      32'hfff8304c
`define ADDR_P5_FUNC    32'hfff83050
`define ADDR_P5_DIR     32'hfff83054
`define ADDR_P5_OUT     32'hfff83058
`define ADDR_P5_IN      32'hfff8305c

`define RST_P2_FUNC     32'h00000000
`define RST_P4_FUNC     32'h00155555
`define RST_P5_FUNC     32'h00000000
`define RST_ZERO        32'h00000000

`define PULLUP_LSB      16
`define P4_PIN_BIT      10
`define P4_FUNC_LSB     20

`define FUNC_GPIO       2'h0
`define FUNC_ALT1       2'h1
`define FUNC_ALT2       2'h2
`define FUNC_ALT3       2'h3

`endif

// File: shared/gpio_mux_pkg.sv
// Types shared by the pin-function mux and its users.
package gpio_mux_pkg;

  typedef logic [1:0] func_sel_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // One bit for each pin of the three ports; oe_n low while the mux drives the pin.
  typedef struct packed {
    logic [9:0] p2;
    logic       p4;
    logic [12:0] p5;
  } pin_vec_t;

  // Peripheral-side signals driven into pins.
  typedef struct packed {
    logic [1:0] phy_tx_data;
    logic       phy_transmit_enable;
    logic       phy_mgmt_data_out;
    logic       phy_mgmt_data_oe;
    logic       phy_mgmt_clock;
    logic [3:0] keypad_row;
    logic [1:0] uart0_txd;
    logic       uart1_txd;
    logic       uart1_request_to_send;
    logic       uart2_txd;
    logic [1:0] twowire_scl_drive_low;
    logic [1:0] twowire_sda_drive_low;
    logic       sync_serial_frame;
    logic       sync_serial_tx;
    logic       sync_serial_clock;
    logic       sync_serial_rx_out;
    logic       sync_serial_rx_oe;
    logic       keyboard_if_clock;
    logic       keyboard_if_data_out;
    logic       keyboard_if_data_oe;
    logic       output_a;
    logic       output_b;
    logic       watchdog_out_n;
    logic       usb_power_enable;
  } periph_out_t;

  // Pin levels routed back to peripherals, each valid when its function is selected.
  typedef struct packed {
    logic       phy_receive_error;
    logic       phy_carrier_valid;
    logic [1:0] phy_rx_data;
    logic       phy_reference_clock;
    logic       phy_mgmt_data_in;
    logic [7:0] keypad_column;
    logic       external_wait_n;
    logic       ext_interrupt3_n;
    logic       uart0_rxd;
    logic       uart1_rxd;
    logic       uart1_clear_to_send;
    logic       uart2_rxd;
    logic [1:0] twowire_scl_in;
    logic [1:0] twowire_sda_in;
    logic       sync_serial_rx;
    logic       keyboard_if_data_in;
    logic       ext_interrupt0_n;
    logic       ext_interrupt1_n;
    logic       usb_overcurrent;
  } periph_in_t;

endpackage

// File: rtl/gpio_port_pin_function_mux.sv
// Register file, pin drivers and function routing for the three muxed ports.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "gpio_mux_regs.svh"

module gpio_port_pin_function_mux (
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  input  wire gpio_mux_pkg::bus_req_t    bus_i,
  output logic        [31:0]             rdata_o,
  input  wire gpio_mux_pkg::pin_vec_t    pin_i,
  output gpio_mux_pkg::pin_vec_t         pin_o,
  output gpio_mux_pkg::pin_vec_t         pin_oe_n_o,
  output gpio_mux_pkg::pin_vec_t         pin_pullup_o,
  input  wire gpio_mux_pkg::periph_out_t periph_i,
  output gpio_mux_pkg::periph_in_t       periph_o
);
  import gpio_mux_pkg::*;

  // ******************************************************************
  // Registers
  // ******************************************************************
  logic [19:0] p2_func_r;
  logic [9:0]  p2_pullup_r;
  logic [9:0]  p2_omode_r;
  logic [9:0]  p2_out_r;
  func_sel_t   p4_func_r;
  logic        p4_pullup_r;
  logic        p4_omode_r;
  logic        p4_out_r;
  logic [25:0] p5_func_r;
  logic [12:0] p5_pullup_r;
  logic [12:0] p5_omode_r;
  logic [12:0] p5_out_r;

  // Reset value of the single-pin config keeps only the field that exists.
  localparam logic [31:0] P4_FUNC_RST = `RST_P4_FUNC;

  wire wr_p2_func = bus_i.wr && (bus_i.addr == `ADDR_P2_FUNC);
  wire wr_p2_dir  = bus_i.wr && (bus_i.addr == `ADDR_P2_DIR);
  wire wr_p2_out  = bus_i.wr && (bus_i.addr == `ADDR_P2_OUT);
  wire wr_p4_func = bus_i.wr && (bus_i.addr == `ADDR_P4_FUNC);
  wire wr_p4_dir  = bus_i.wr && (bus_i.addr == `ADDR_P4_DIR);
  wire wr_p4_out  = bus_i.wr && (bus_i.addr == `ADDR_P4_OUT);
  wire wr_p5_func = bus_i.wr && (bus_i.addr == `ADDR_P5_FUNC);
  wire wr_p5_dir  = bus_i.wr && (bus_i.addr == `ADDR_P5_DIR);
  wire wr_p5_out  = bus_i.wr && (bus_i.addr == `ADDR_P5_OUT);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      p2_func_r   <= 20'(`RST_P2_FUNC);                            // RL17
      p4_func_r   <= P4_FUNC_RST[`P4_FUNC_LSB +: 2];               // RL4
      p5_func_r   <= 26'(`RST_P5_FUNC);                            // RL7
      p2_pullup_r <= '0;                                           // RL9
      p4_pullup_r <= 1'b0;
      p5_pullup_r <= '0;
      p2_omode_r  <= '0;                                           // RL16
      p4_omode_r  <= 1'b0;
      p5_omode_r  <= '0;
      p2_out_r    <= '0;
      p4_out_r    <= 1'b0;
      p5_out_r    <= '0;
    end else begin
      if (wr_p2_func) p2_func_r <= bus_i.wdata[19:0];              // RL1
      if (wr_p4_func) p4_func_r <= bus_i.wdata[`P4_FUNC_LSB +: 2];
      if (wr_p5_func) p5_func_r <= bus_i.wdata[25:0];
      if (wr_p2_dir) begin
        p2_pullup_r <= bus_i.wdata[`PULLUP_LSB +: 10];             // RL8
        p2_omode_r  <= bus_i.wdata[9:0];                           // RL10
      end
      if (wr_p4_dir) begin
        p4_pullup_r <= bus_i.wdata[`PULLUP_LSB + `P4_PIN_BIT];
        p4_omode_r  <= bus_i.wdata[`P4_PIN_BIT];
      end
      if (wr_p5_dir) begin
        p5_pullup_r <= bus_i.wdata[`PULLUP_LSB +: 13];
        p5_omode_r  <= bus_i.wdata[12:0];
      end
      // Only implemented bits are stored, so reserved writes have no effect.
      if (wr_p2_out) p2_out_r <= bus_i.wdata[9:0];                 // RL13
      if (wr_p4_out) p4_out_r <= bus_i.wdata[`P4_PIN_BIT];
      if (wr_p5_out) p5_out_r <= bus_i.wdata[12:0];
    end
  end

  // ******************************************************************
  // Input synchroniser
  // ******************************************************************
  pin_vec_t meta_r;
  pin_vec_t sync_r;

  always_ff @(posedge clock_i) begin
    meta_r <= pin_i;                                               // RL19
    sync_r <= meta_r;
  end

  // ******************************************************************
  // Read path
  // ******************************************************************
  logic [31:0] rdata_nxt;

  assign rdata_nxt =
    !bus_i.rd                      ? 32'h00000000 :
    bus_i.addr == `ADDR_P2_FUNC    ? {12'h000, p2_func_r} :
    bus_i.addr == `ADDR_P2_DIR     ? {6'h00, p2_pullup_r, 6'h00, p2_omode_r} :
    bus_i.addr == `ADDR_P2_OUT     ? {22'h000000, p2_out_r} :
    bus_i.addr == `ADDR_P2_IN      ? {22'h000000, sync_r.p2} :      // RL14 RL15
    bus_i.addr == `ADDR_P4_FUNC    ? {10'h000, p4_func_r, 20'h00000} :
    bus_i.addr == `ADDR_P4_DIR     ? {5'h00, p4_pullup_r, 15'h0000, p4_omode_r, 10'h000} :
    bus_i.addr == `ADDR_P4_OUT     ? {21'h000000, p4_out_r, 10'h000} :
    bus_i.addr == `ADDR_P4_IN      ? {21'h000000, sync_r.p4, 10'h000} :
    bus_i.addr == `ADDR_P5_FUNC    ? {6'h00, p5_func_r} :
    bus_i.addr == `ADDR_P5_DIR     ? {3'h0, p5_pullup_r, 3'h0, p5_omode_r} :
    bus_i.addr == `ADDR_P5_OUT     ? {19'h00000, p5_out_r} :
    bus_i.addr == `ADDR_P5_IN      ? {19'h00000, sync_r.p5} :
                                     32'h00000000;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // ******************************************************************
  // Pin drive selection
  // ******************************************************************
  // Each pin: data, active-low enable. Plain I/O uses the direction bit.
  function automatic logic [1:0] pin_drive(input func_sel_t sel,
                                           input logic omode,
                                           input logic dout,
                                           input logic [1:0] f1,
                                           input logic [1:0] f2,
                                           input logic [1:0] f3);
    logic [1:0] res;
    res = 2'b01;
    unique case (sel)
      `FUNC_GPIO: res = {dout, ~omode};                            // RL11 RL12 RL20
      `FUNC_ALT1: res = f1;
      `FUNC_ALT2: res = f2;
      `FUNC_ALT3: res = f3;
    endcase
    return res;
  endfunction

  localparam logic [1:0] IN_ONLY = 2'b01;
  function automatic logic [1:0] drv(input logic d);
    return {d, 1'b0};
  endfunction
  function automatic logic [1:0] open_low(input logic low);
    return {1'b0, ~low};
  endfunction

  pin_vec_t    pin_nxt;
  pin_vec_t    oe_n_nxt;
  logic [1:0]  p2_f1 [10];
  logic [1:0]  p2_f2 [10];
  logic [1:0]  p5_f1 [13];
  logic [1:0]  p5_f2 [13];
  logic [1:0]  p5_f3 [13];

  always_comb begin
    // Ten-pin port: receive side inputs, then transmit and management.
    for (int i = 0; i < 10; i++) begin
      p2_f1[i] = IN_ONLY;                                          // RL2 RL18
      p2_f2[i] = IN_ONLY;
    end
    p2_f1[5] = drv(periph_i.phy_transmit_enable);
    p2_f1[6] = drv(periph_i.phy_tx_data[0]);
    p2_f1[7] = drv(periph_i.phy_tx_data[1]);
    p2_f1[8] = {periph_i.phy_mgmt_data_out, ~periph_i.phy_mgmt_data_oe};
    p2_f1[9] = drv(periph_i.phy_mgmt_clock);
    p2_f2[8] = drv(periph_i.keypad_row[0]);
    p2_f2[9] = drv(periph_i.keypad_row[1]);
    for (int i = 0; i < 13; i++) begin
      p5_f1[i] = IN_ONLY;                                          // RL5
      p5_f2[i] = IN_ONLY;
      p5_f3[i] = IN_ONLY;
    end
    p5_f1[0]  = drv(periph_i.uart0_txd[0]);
    p5_f1[2]  = drv(periph_i.uart1_txd);
    p5_f1[4]  = drv(periph_i.uart0_txd[1]);
    p5_f1[6]  = open_low(periph_i.twowire_scl_drive_low[0]);
    p5_f1[7]  = open_low(periph_i.twowire_sda_drive_low[0]);
    p5_f1[8]  = open_low(periph_i.twowire_scl_drive_low[1]);
    p5_f1[9]  = open_low(periph_i.twowire_sda_drive_low[1]);
    p5_f1[10] = drv(periph_i.watchdog_out_n);
    p5_f2[5]  = drv(periph_i.uart1_request_to_send);
    p5_f2[6]  = drv(periph_i.sync_serial_frame);
    p5_f2[7]  = drv(periph_i.sync_serial_tx);
    p5_f2[8]  = drv(periph_i.sync_serial_clock);
    p5_f2[9]  = {periph_i.sync_serial_rx_out, ~periph_i.sync_serial_rx_oe};
    p5_f2[10] = drv(periph_i.usb_power_enable);
    p5_f3[4]  = drv(periph_i.keyboard_if_clock);
    p5_f3[5]  = {periph_i.keyboard_if_data_out, ~periph_i.keyboard_if_data_oe};
    p5_f3[6]  = drv(periph_i.output_a);
    p5_f3[7]  = drv(periph_i.output_b);
    p5_f3[8]  = drv(periph_i.keypad_row[2]);
    p5_f3[9]  = drv(periph_i.keypad_row[3]);
    pin_nxt  = '0;
    oe_n_nxt = '1;
    for (int i = 0; i < 10; i++) begin
      {pin_nxt.p2[i], oe_n_nxt.p2[i]} =
        pin_drive(p2_func_r[2*i +: 2], p2_omode_r[i], p2_out_r[i], p2_f1[i], p2_f2[i], IN_ONLY);
    end
    // Wait and interrupt 3 are inputs, so both alternates leave the pin floating.
    {pin_nxt.p4, oe_n_nxt.p4} =
      pin_drive(p4_func_r, p4_omode_r, p4_out_r, IN_ONLY, IN_ONLY, IN_ONLY);   // RL3
    for (int i = 0; i < 13; i++) begin
      {pin_nxt.p5[i], oe_n_nxt.p5[i]} =
        pin_drive(p5_func_r[2*i +: 2], p5_omode_r[i], p5_out_r[i], p5_f1[i], p5_f2[i], p5_f3[i]);
    end
  end

  // ******************************************************************
  // Peripheral inputs
  // ******************************************************************
  // Inputs idle high when their function is not selected, matching idle active-low lines.
  function automatic logic pick(input func_sel_t sel, input func_sel_t want, input logic lvl);
    return (sel == want) ? lvl : 1'b1;
  endfunction

  periph_in_t periph_nxt;

  always_comb begin
    periph_nxt.phy_receive_error   = pick(p2_func_r[1:0], `FUNC_ALT1, sync_r.p2[0]);  // RL18
    periph_nxt.phy_carrier_valid   = pick(p2_func_r[3:2], `FUNC_ALT1, sync_r.p2[1]);  // RL2
    periph_nxt.phy_rx_data[0]      = pick(p2_func_r[5:4], `FUNC_ALT1, sync_r.p2[2]);
    periph_nxt.phy_rx_data[1]      = pick(p2_func_r[7:6], `FUNC_ALT1, sync_r.p2[3]);
    periph_nxt.phy_reference_clock = pick(p2_func_r[9:8], `FUNC_ALT1, sync_r.p2[4]);
    periph_nxt.phy_mgmt_data_in    = pick(p2_func_r[17:16], `FUNC_ALT1, sync_r.p2[8]);
    for (int i = 0; i < 8; i++) begin
      periph_nxt.keypad_column[i] = pick(p2_func_r[2*i +: 2], `FUNC_ALT2, sync_r.p2[i]);
    end
    periph_nxt.external_wait_n     = pick(p4_func_r, `FUNC_ALT1, sync_r.p4);          // RL3
    periph_nxt.ext_interrupt3_n    = pick(p4_func_r, `FUNC_ALT2, sync_r.p4);
    periph_nxt.uart0_rxd           = pick(p5_func_r[3:2], `FUNC_ALT1, sync_r.p5[1]);  // RL5
    periph_nxt.uart1_rxd           = pick(p5_func_r[7:6], `FUNC_ALT1, sync_r.p5[3]);
    periph_nxt.uart1_clear_to_send = pick(p5_func_r[9:8], `FUNC_ALT2, sync_r.p5[4]);
    periph_nxt.uart2_rxd           = pick(p5_func_r[11:10], `FUNC_ALT1, sync_r.p5[5]);
    periph_nxt.twowire_scl_in[0]   = pick(p5_func_r[13:12], `FUNC_ALT1, sync_r.p5[6]);
    periph_nxt.twowire_sda_in[0]   = pick(p5_func_r[15:14], `FUNC_ALT1, sync_r.p5[7]);
    periph_nxt.twowire_scl_in[1]   = pick(p5_func_r[17:16], `FUNC_ALT1, sync_r.p5[8]);
    periph_nxt.twowire_sda_in[1]   = pick(p5_func_r[19:18], `FUNC_ALT1, sync_r.p5[9]);
    periph_nxt.sync_serial_rx      = pick(p5_func_r[19:18], `FUNC_ALT2, sync_r.p5[9]);
    periph_nxt.keyboard_if_data_in = pick(p5_func_r[11:10], `FUNC_ALT3, sync_r.p5[5]);
    periph_nxt.ext_interrupt0_n    = pick(p5_func_r[23:22], `FUNC_ALT1, sync_r.p5[11]); // RL6
    periph_nxt.ext_interrupt1_n    = pick(p5_func_r[25:24], `FUNC_ALT1, sync_r.p5[12]);
    periph_nxt.usb_overcurrent     = pick(p5_func_r[25:24], `FUNC_ALT2, sync_r.p5[12]);
  end

  // ******************************************************************
  // Output flip-flops
  // ******************************************************************
  // Registering the pins costs one cycle of latency but keeps glitches off the pads.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pin_o        <= '0;
      pin_oe_n_o   <= '1;                                          // RL20
      pin_pullup_o <= '0;
      periph_o     <= '1;
    end else begin
      pin_o        <= pin_nxt;
      pin_oe_n_o   <= oe_n_nxt;
      pin_pullup_o <= {p2_pullup_r, p4_pullup_r, p5_pullup_r};     // RL8 RL20
      periph_o     <= periph_nxt;
    end
  end

endmodule

// File: testbench/gpio_mux_checker.sv
// Concurrent checks of the pin-function mux register bus and pad outputs.
`timescale 1ns/10ps
`include "gpio_mux_regs.svh"
module gpio_mux_checker (
  input wire logic                   clock_i,
  input wire logic                   reset_i,
  input wire gpio_mux_pkg::bus_req_t bus_i,
  input wire logic [31:0]            rdata_o,
  input wire gpio_mux_pkg::pin_vec_t pin_i,
  input wire gpio_mux_pkg::pin_vec_t pin_o,
  input wire gpio_mux_pkg::pin_vec_t pin_oe_n_o,
  input wire gpio_mux_pkg::pin_vec_t pin_pullup_o
);
  import gpio_mux_pkg::*;
  wire at_p2_func = bus_i.addr == `ADDR_P2_FUNC;
  wire at_p2_dir  = bus_i.addr == `ADDR_P2_DIR;
  wire at_p2_out  = bus_i.addr == `ADDR_P2_OUT;
  wire at_p2_in   = bus_i.addr == `ADDR_P2_IN;
  wire at_p4_func = bus_i.addr == `ADDR_P4_FUNC;
  wire at_p4_in   = bus_i.addr == `ADDR_P4_IN;
  wire at_p5_out  = bus_i.addr == `ADDR_P5_OUT;
  wire at_hole    = bus_i.addr == 32'hfff83030;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // ****************
  // Assertions
  // ****************
  AST_RDATA_IDLE:
  assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0) else $error("read data not idle");
  AST_HOLE_ZERO:
  assert property (bus_i.rd && at_hole |=> rdata_o == 32'h0) else $error("hole read not zero");
  AST_IN2_RSVD:
  assert property (bus_i.rd && at_p2_in |=> rdata_o[31:10] == 22'h0) else $error("p2 in rsvd");
  AST_IN4_RSVD:
  assert property (bus_i.rd && at_p4_in |=> (rdata_o & 32'hfffffbff) == 32'h0)
    else $error("p4 in rsvd");
  AST_OUT5_RSVD:
  assert property (bus_i.rd && at_p5_out |=> rdata_o[31:13] == 19'h0) else $error("p5 out rsvd");
  AST_DIR2_RSVD:
  assert property (bus_i.rd && at_p2_dir |=> (rdata_o & 32'hfc00fc00) == 32'h0)
    else $error("p2 dir rsvd");
  AST_FUNC_READBACK:
  assert property (bus_i.wr && at_p2_func ##1 bus_i.rd && at_p2_func
    |=> rdata_o == {12'h0, $past(bus_i.wdata[19:0], 2)}) else $error("p2 func readback");
  AST_P4_FIELD:
  assert property (bus_i.rd && at_p4_func |=> (rdata_o & 32'hffcfffff) == 32'h0)
    else $error("p4 func field");
  AST_RESET_PADS:
  assert property ($fell(reset_i) |-> pin_oe_n_o == 24'hffffff && pin_pullup_o == 24'h0
    && pin_o == 24'h0) else $error("pads after reset");
  AST_PULLUP_FOLLOW:
  assert property (bus_i.wr && at_p2_dir ##1 !(bus_i.wr && at_p2_dir)
    |=> pin_pullup_o.p2 == $past(bus_i.wdata[25:16], 2)) else $error("pull-up lag");
  AST_GPIO_DRIVE:
  assert property (bus_i.wr && at_p2_out ##2 !pin_oe_n_o.p2[0]
    |-> pin_o.p2[0] == $past(bus_i.wdata[0], 2)) else $error("pad data lag");
  AST_IN_SYNC:
  assert property (bus_i.rd && at_p2_in && $stable(pin_i.p2) && $past(pin_i.p2, 2) == pin_i.p2
    && $past(pin_i.p2, 3) == pin_i.p2 |=> rdata_o[9:0] == $past(pin_i.p2))
    else $error("input register stale");
  cover property (bus_i.wr && at_p2_func ##1 bus_i.rd && at_p2_func);
  cover property (bus_i.rd && at_hole);
  cover property (bus_i.wr && at_p2_out ##2 !pin_oe_n_o.p2[0]);
endmodule

bind gpio_port_pin_function_mux gpio_mux_checker u_gpio_mux_checker (.clock_i(clock_i),
  .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_n_o(pin_oe_n_o), .pin_pullup_o(pin_pullup_o));

// File: testbench/pad_model.sv
// Pad model that resolves each pin from the mux, an outside driver and the pull-up.
`timescale 1ns/10ps
module pad_model (
  input  wire logic                   clock_i,
  input  wire gpio_mux_pkg::pin_vec_t pad_data_i,
  input  wire gpio_mux_pkg::pin_vec_t pad_oe_n_i,
  input  wire gpio_mux_pkg::pin_vec_t pullup_i,
  input  wire gpio_mux_pkg::pin_vec_t ext_level_i,
  input  wire gpio_mux_pkg::pin_vec_t ext_drive_i,
  output gpio_mux_pkg::pin_vec_t      level_o
);
  import gpio_mux_pkg::*;
  // ****************
  // Pad resolution
  // ****************
  // A floating pad flips every cycle, so a read of it can never match by luck.
  logic [23:0] float_r = 24'h0;
  always @(posedge clock_i) begin
    float_r <= ~float_r;
  end
  assign level_o = (~pad_oe_n_i & pad_data_i) | (pad_oe_n_i & ext_drive_i & ext_level_i)
    | (pad_oe_n_i & ~ext_drive_i & (pullup_i | float_r));
endmodule

// File: testbench/gpio_port_pin_function_mux_bench.sv
// Self-checking bench of the pin-function mux with a pad model on its pins.
`timescale 1ns/10ps
`include "gpio_mux_regs.svh"
module gpio_port_pin_function_mux_bench;
  import gpio_mux_pkg::*;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  bus_req_t    bus_i = '0;
  logic [31:0] rdata_o;
  pin_vec_t    pin_i, pin_o, pin_oe_n_o, pin_pullup_o;
  pin_vec_t    ext_level = '0;
  pin_vec_t    ext_drive = '0;
  periph_out_t periph_i = '0;
  periph_in_t  periph_o;
  int          fail_count = 0;
  int          n_compared = 0;
  logic [31:0] addr_tab [9] = '{`ADDR_P2_FUNC, `ADDR_P2_DIR, `ADDR_P2_OUT, `ADDR_P4_FUNC,
    `ADDR_P4_DIR, `ADDR_P4_OUT, `ADDR_P5_FUNC, `ADDR_P5_DIR, `ADDR_P5_OUT};
  logic [31:0] mask_tab [9] = '{32'h000fffff, 32'h03ff03ff, 32'h000003ff, 32'h00300000,
    32'h04000400, 32'h00000400, 32'h03ffffff, 32'h1fff1fff, 32'h00001fff};

  gpio_port_pin_function_mux u_gpio_port_pin_function_mux (.clock_i(clock_i), .reset_i(reset_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
    .pin_pullup_o(pin_pullup_o), .periph_i(periph_i), .periph_o(periph_o));
  pad_model u_pad_model (.clock_i(clock_i), .pad_data_i(pin_o), .pad_oe_n_i(pin_oe_n_o),
    .pullup_i(pin_pullup_o), .ext_level_i(ext_level), .ext_drive_i(ext_drive), .level_o(pin_i));

  // ****************
  // Helpers
  // ****************
  initial begin
    forever #2.5 clock_i = ~clock_i;
  end
  function automatic logic [23:0] pad_level(input logic [23:0] om, d, dr, ev, pu);
    return (om & d) | (~om & dr & ev) | (~om & ~dr & pu);
  endfunction
  task automatic check(input string n, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic req(input logic w, input logic [31:0] a, d);
    @(posedge clock_i);
    bus_i <= '{addr: a, wdata: d, wr: w, rd: !w};
  endtask
  task automatic idle(input int n);
    @(posedge clock_i);
    bus_i <= '0;
    pause(n);
    #1;
  endtask
  // The answer stands only in the cycle after the read edge, so it is taken there.
  task automatic rchk(input string n, input logic [31:0] a, exp, m);
    req(1'b0, a, 32'h0);
    @(posedge clock_i);
    bus_i <= '0;
    #1 check(n, rdata_o & m, exp);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    pause(5000);
    fail_count++;
    test_done();
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [23:0] om, d, pu, dr, ev, lk;
    logic [31:0] r;
    logic [1:0]  f;
    void'($urandom(32'ha70b));
    pause(8);
    reset_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      r = mask_tab[i] & (i == 3 ? `RST_P4_FUNC : `RST_ZERO);
      rchk("reset value", addr_tab[i], r, '1);
    end
    check("reset oe_n", 32'(pin_oe_n_o), 32'h00ffffff);
    repeat (3) for (int i = 0; i < 9; i++) begin
      r = $urandom();
      req(1'b1, addr_tab[i], r);
      rchk("readback", addr_tab[i], r & mask_tab[i], '1);
    end
    req(1'b1, `ADDR_P2_IN, '1);
    rchk("unmapped", 32'hfff83030, 32'h0, '1);
    req(1'b1, `ADDR_P2_FUNC, 32'h0);
    req(1'b1, `ADDR_P4_FUNC, 32'h0);
    req(1'b1, `ADDR_P5_FUNC, 32'h0);
    repeat (4) begin
      om = 24'($urandom());
      d = 24'($urandom());
      pu = 24'($urandom());
      dr = 24'($urandom());
      ev = 24'($urandom());
      ext_drive <= dr;
      ext_level <= ev;
      req(1'b1, `ADDR_P2_DIR, {6'h0, pu[23:14], 6'h0, om[23:14]});
      req(1'b1, `ADDR_P4_DIR, {5'h0, pu[13], 15'h0, om[13], 10'h0});
      req(1'b1, `ADDR_P5_DIR, {3'h0, pu[12:0], 3'h0, om[12:0]});
      req(1'b1, `ADDR_P2_OUT, {22'h0, d[23:14]});
      req(1'b1, `ADDR_P4_OUT, {21'h0, d[13], 10'h0});
      req(1'b1, `ADDR_P5_OUT, {19'h0, d[12:0]});
      idle(6);
      lk = pad_level(om, d, dr, ev, pu) & (om | dr | pu);
      check("pad enable", 32'(pin_oe_n_o), {8'h0, ~om});
      check("pad data", 32'(pin_o & om), {8'h0, d & om});
      check("pull-up", 32'(pin_pullup_o), {8'h0, pu});
      dr = dr | om | pu;
      rchk("p2 in", `ADDR_P2_IN, {22'h0, lk[23:14]}, {22'h3fffff, dr[23:14]});
      rchk("p4 in", `ADDR_P4_IN, {21'h0, lk[13], 10'h0}, {21'h1fffff, dr[13], 10'h3ff});
      rchk("p5 in", `ADDR_P5_IN, {19'h0, lk[12:0]}, {19'h7ffff, dr[12:0]});
    end
    ext_drive <= '1;
    req(1'b1, `ADDR_P2_DIR, 32'h3ff);
    req(1'b1, `ADDR_P4_DIR, 32'h400);
    req(1'b1, `ADDR_P5_DIR, 32'h1fff);
    for (int c = 1; c < 4; c++) begin
      f = 2'(c);
      r = $urandom();
      periph_i <= periph_out_t'(r[$bits(periph_out_t)-1:0]);
      ext_level <= 24'($urandom());
      req(1'b1, `ADDR_P2_FUNC, {12'h0, {10{f}}});
      req(1'b1, `ADDR_P4_FUNC, {10'h0, f, 20'h0});
      req(1'b1, `ADDR_P5_FUNC, {6'h0, {13{f}}});
      idle(6);
      case (c)
        1: begin
          check("rx error pad", 32'(pin_oe_n_o.p2[0]), 32'h1);
          check("rx error", 32'(periph_o.phy_receive_error), 32'(pin_i.p2[0]));
          r = 32'({pin_oe_n_o.p2[5], pin_o.p2[5]});
          check("tx enable", r, 32'(periph_i.phy_transmit_enable));
          check("wait", 32'(periph_o.external_wait_n), 32'(pin_i.p4));
          r = 32'({periph_o.ext_interrupt1_n, periph_o.ext_interrupt0_n});
          check("irq0 irq1", r, 32'(pin_i.p5[12:11]));
          r = 32'({pin_oe_n_o.p5[6], pin_o.p5[6]});
          check("twowire0_clock pad", r, 32'({~periph_i.twowire_scl_drive_low[0], 1'b0}));
        end
        2: begin
          check("keypad col", 32'(periph_o.keypad_column), 32'(pin_i.p2[7:0]));
          check("keypad row", 32'(pin_o.p2[8]), 32'(periph_i.keypad_row[0]));
          check("irq3", 32'(periph_o.ext_interrupt3_n), 32'(pin_i.p4));
          check("overcurrent", 32'(periph_o.usb_overcurrent), 32'(pin_i.p5[12]));
          check("usb power", 32'(pin_o.p5[10]), 32'(periph_i.usb_power_enable));
        end
        default: begin
          r = 32'({pin_oe_n_o.p2, pin_oe_n_o.p4, pin_oe_n_o.p5[12:10], pin_oe_n_o.p5[3:0]});
          check("reserved pads", r, 32'h3ffff);
          r = 32'({pin_oe_n_o.p5[7:6], pin_o.p5[7:6]});
          check("timer pads", r, 32'({2'b00, periph_i.output_b, periph_i.output_a}));
        end
      endcase
      rchk("p2 in alt", `ADDR_P2_IN, {22'h0, pin_i.p2}, '1);
    end
    test_done();
  end
endmodule
